// [rtl/grc_pkg.sv]
package grc_pkg;

  // ****************************************************************
  // Widths and values
  // ****************************************************************
  localparam int GRC_W = 16;
  localparam int GRC_NIB = 4;
  localparam int GRC_DIGITS = 4;
  localparam logic [15:0] GRC_MODE_RST = 16'h0800;
  localparam logic [15:0] GRC_DOWN_TC = 16'h0001;
  localparam logic [15:0] GRC_BCD_TC = 16'h9999;
  localparam logic [15:0] GRC_BIN_TC = 16'hffff;
  localparam logic [3:0] GRC_NIB_MAX = 4'h9;
  localparam logic [3:0] GRC_NIB_ZERO = 4'h0;
  localparam logic [3:0] GRC_NIB_ONE = 4'h1;

  // ****************************************************************
  // Mode word field positions
  // ****************************************************************
  localparam int GRC_BIT_GATE_ON = 15;
  localparam int GRC_BIT_GATE_EDGE = 14;
  localparam int GRC_BIT_GATE_LOW = 13;
  localparam int GRC_BIT_OP_HI = 7;
  localparam int GRC_BIT_OP_LO = 5;
  localparam int GRC_BIT_BCD = 4;
  localparam int GRC_BIT_UP = 3;

  typedef enum logic [2:0] {
    GRC_OP_DUAL = 3'h3,
    GRC_OP_STROBE = 3'h4,
    GRC_OP_SYNC = 3'h5,
    GRC_OP_RELSEL = 3'h6
  } grc_op_t;

  typedef struct packed {
    logic arm;
    logic disarm;
    logic load;
  } grc_cmd_t;

  typedef struct packed {
    logic armed;
    logic running;
    logic second_phase;
    logic reload_pending;
  } grc_stat_t;

endpackage

// [rtl/grc_counter.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - Dual-reload one-shot starts only on a gate edge while armed; disarmed edges ignored.
// - Dual-reload one-shot ignores the gate once triggered until the cycle ends.
// - Dual-reload one-shot: first TC reloads hold, second reloads load and stops.
// - Level strobe mode needs arm, then counts only source edges with gate active.
// - Level strobe mode: TC reloads from load register and disarms.
// - Level strobe: gate edge when armed saves count; next edge loads; then resume.
// - Level retrigger modes count only active source edges while gate is active.
// - Mode bits 7..5 = 100 with edge gating: gate edge starts, level ignored.
// - Edge strobe counts all edges to first TC, reloads load, disarms; host rearms.
// - Edge strobe: every gate edge while armed saves count, next edge loads, second resumes.
// - Sync rate generator counts qualified edges, reloads load at each TC, repeats.
// - Sync rate generator: gate edge anytime saves count, next edge loads, resume.
// - Retriggerable one-shot starts on gate edge, then counts all edges to TC.
// - Retriggerable one-shot: TC reloads load and stops, stays armed for next edge.
// - Retriggerable one-shot: every gate edge while armed saves count, next loads, second resumes.
// - Bits 15..13 = 000 and 7..5 = 110 select gate-chosen reload source always.
// - Gate low selects load register, high selects hold; gate never gates counting.
// - Gate-selected reload mode disarms after the second TC; host must rearm.
// - TC occurs on next count from 0001 down, 9999 BCD up, FFFF binary up.
// - Terminal count stays active for exactly one count-source cycle.
module grc_counter (
  input wire logic clock,
  input wire logic rst,
  input wire logic src_pulse,
  input wire logic gate,
  input wire grc_pkg::grc_cmd_t cmd,
  input wire logic mode_wr,
  input wire logic [grc_pkg::GRC_W-1:0] mode_wdata,
  input wire logic load_wr,
  input wire logic [grc_pkg::GRC_W-1:0] load_wdata,
  input wire logic hold_wr,
  input wire logic [grc_pkg::GRC_W-1:0] hold_wdata,
  output logic [grc_pkg::GRC_W-1:0] mode_word_r,
  output logic [grc_pkg::GRC_W-1:0] load_r,
  output logic [grc_pkg::GRC_W-1:0] hold_r,
  output logic [grc_pkg::GRC_W-1:0] count_r,
  output logic terminal_count,
  output grc_pkg::grc_stat_t status
);
  import grc_pkg::*;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  logic mode_word_bit15, mode_word_bit14, mode_word_bit13;
  logic [2:0] op_field;
  logic gate_lvl, gate_edge_mode, gate_act, gate_d_r, gate_rise;
  logic m_dual, m_lstrobe, m_estrobe, m_sync, m_retrig, m_relsel;
  logic armed_r, run_r, phase_r, pend_r, tc_r;
  logic count_up, count_bcd, at_tc, enable, go, hit, save_ev, trig;
  logic [GRC_W-1:0] reload_val, load_src, step_val;

  assign mode_word_bit15 = mode_word_r[GRC_BIT_GATE_ON];
  assign mode_word_bit14 = mode_word_r[GRC_BIT_GATE_EDGE];
  assign mode_word_bit13 = mode_word_r[GRC_BIT_GATE_LOW];
  assign op_field = mode_word_r[GRC_BIT_OP_HI:GRC_BIT_OP_LO];
  assign gate_lvl = mode_word_bit15 & ~mode_word_bit14;
  assign gate_edge_mode = mode_word_bit15 & mode_word_bit14;
  assign gate_act = gate ^ (mode_word_bit15 & mode_word_bit13);
  assign gate_rise = gate_act & ~gate_d_r;
  assign count_up = mode_word_r[GRC_BIT_UP];
  assign count_bcd = mode_word_r[GRC_BIT_BCD];

  always_comb begin
    m_dual = (op_field == GRC_OP_DUAL) && gate_edge_mode;
    m_lstrobe = (op_field == GRC_OP_STROBE) && gate_lvl;
    m_estrobe = (op_field == GRC_OP_STROBE) && gate_edge_mode;
    m_sync = (op_field == GRC_OP_SYNC) && gate_lvl;
    m_retrig = (op_field == GRC_OP_SYNC) && gate_edge_mode;
    m_relsel = (op_field == GRC_OP_RELSEL) && !mode_word_bit15 && !mode_word_bit14 && !mode_word_bit13;
  end

  // ****************************************************************
  // Count arithmetic
  // ****************************************************************
  function automatic logic [GRC_W-1:0] bcd_step(input logic [GRC_W-1:0] v, input logic up);
    logic [GRC_W-1:0] r;
    logic c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < GRC_DIGITS; i++) begin
      if (c) begin
        if (up) begin
          if (v[i*GRC_NIB +: GRC_NIB] == GRC_NIB_MAX) begin
            r[i*GRC_NIB +: GRC_NIB] = GRC_NIB_ZERO;
          end else begin
            r[i*GRC_NIB +: GRC_NIB] = v[i*GRC_NIB +: GRC_NIB] + GRC_NIB_ONE;
            c = 1'b0;
          end
        end else begin
          if (v[i*GRC_NIB +: GRC_NIB] == GRC_NIB_ZERO) begin
            r[i*GRC_NIB +: GRC_NIB] = GRC_NIB_MAX;
          end else begin
            r[i*GRC_NIB +: GRC_NIB] = v[i*GRC_NIB +: GRC_NIB] - GRC_NIB_ONE;
            c = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  always_comb begin
    if (count_bcd) begin
      step_val = bcd_step(count_r, count_up);
    end else if (count_up) begin
      step_val = count_r + GRC_DOWN_TC;
    end else begin
      step_val = count_r - GRC_DOWN_TC;
    end
    if (!count_up) begin
      at_tc = (count_r == GRC_DOWN_TC);
    end else if (count_bcd) begin
      at_tc = (count_r == GRC_BCD_TC);
    end else begin
      at_tc = (count_r == GRC_BIN_TC);
    end
  end

  // ****************************************************************
  // Event decode
  // ****************************************************************
  always_comb begin
    if (m_dual || m_estrobe || m_retrig) begin
      enable = armed_r && run_r;
    end else begin
      enable = armed_r;
    end
    // Level gating qualifies source edges
    go = src_pulse && enable && !tc_r && (!gate_lvl || gate_act);
    hit = go && !pend_r && at_tc;
    trig = gate_rise && armed_r && !run_r && (m_dual || m_estrobe || m_retrig);
    if (m_lstrobe || m_estrobe || m_retrig) begin
      save_ev = gate_rise && armed_r;
    end else begin
      save_ev = gate_rise && m_sync;
    end
    load_src = (m_relsel && gate_act) ? hold_r : load_r;
    if (m_relsel) begin
      reload_val = load_src;
    end else if (m_dual) begin
      reload_val = phase_r ? load_r : hold_r;
    end else begin
      reload_val = load_r;
    end
  end

  // ****************************************************************
  // Host registers
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_word_r <= GRC_MODE_RST;
    end else if (mode_wr) begin
      mode_word_r <= mode_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      load_r <= '0;
    end else if (load_wr) begin
      load_r <= load_wdata;
    end
  end

  // Hardware save wins over a host write in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_r <= '0;
    end else if (save_ev) begin
      hold_r <= count_r;
    end else if (hold_wr) begin
      hold_r <= hold_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gate_d_r <= 1'b0;
    end else begin
      gate_d_r <= gate_act;
    end
  end

  // ****************************************************************
  // Counter and terminal count
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else if (cmd.load) begin
      count_r <= load_src;
    end else if (go && pend_r) begin
      count_r <= load_r;
    end else if (hit) begin
      count_r <= reload_val;
    end else if (go) begin
      count_r <= step_val;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tc_r <= 1'b0;
    end else if (hit) begin
      tc_r <= 1'b1;
    end else if (src_pulse) begin
      tc_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequencing state
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      armed_r <= 1'b0;
    end else if (cmd.arm) begin
      armed_r <= 1'b1;
    end else if (cmd.disarm) begin
      armed_r <= 1'b0;
    end else if (hit && (m_lstrobe || m_estrobe || (m_relsel && phase_r))) begin
      armed_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run_r <= 1'b0;
    end else if (trig) begin
      run_r <= 1'b1;
    end else if (hit && (m_estrobe || m_retrig || (m_dual && phase_r))) begin
      run_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_r <= 1'b0;
    end else if (cmd.arm || trig) begin
      phase_r <= 1'b0;
    end else if (hit && (m_dual || m_relsel)) begin
      phase_r <= ~phase_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
    end else if (save_ev) begin
      pend_r <= 1'b1;
    end else if (go) begin
      pend_r <= 1'b0;
    end
  end

  assign terminal_count = tc_r;
  assign status = '{armed: armed_r, running: run_r, second_phase: phase_r, reload_pending: pend_r};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_dual_disarmed;
    m_dual && !armed_r && !run_r && gate_rise && !cmd.arm |=> !run_r;
  endproperty
  a_dual_disarmed: assert property (p_dual_disarmed) else $error("gate edge started disarmed counter");

  property p_dual_hold;
    m_dual && run_r && !hit && !mode_wr |=> run_r;
  endproperty
  a_dual_hold: assert property (p_dual_hold) else $error("triggered counter stopped before second TC");

  property p_dual_first;
    m_dual && hit && !phase_r && !cmd.load && !cmd.arm |=> count_r == $past(hold_r) && phase_r && tc_r;
  endproperty
  a_dual_first: assert property (p_dual_first) else $error("first TC did not reload from hold");

  property p_lstrobe_tc;
    m_lstrobe && hit && !cmd.arm && !cmd.load |=> !armed_r && count_r == $past(load_r);
  endproperty
  a_lstrobe_tc: assert property (p_lstrobe_tc) else $error("level strobe TC did not reload and disarm");

  property p_level_qual;
    gate_lvl && src_pulse && !gate_act && !cmd.load |=> $stable(count_r);
  endproperty
  a_level_qual: assert property (p_level_qual) else $error("counted edge while gate inactive");

  property p_save;
    save_ev |=> hold_r == $past(count_r) && pend_r;
  endproperty
  a_save: assert property (p_save) else $error("gate edge did not save count");

  property p_relsel_load;
    m_relsel && cmd.load && gate_act |=> count_r == $past(hold_r);
  endproperty
  a_relsel_load: assert property (p_relsel_load) else $error("high gate load did not use hold");

  property p_tc_once;
    tc_r && src_pulse |=> !tc_r;
  endproperty
  a_tc_once: assert property (p_tc_once) else $error("terminal count lasted past one source cycle");

  property p_tc_down;
    go && !pend_r && !count_up && count_r == GRC_DOWN_TC && !cmd.load |=> tc_r;
  endproperty
  a_tc_down: assert property (p_tc_down) else $error("count from 0001 did not give TC");

  property p_arm;
    cmd.arm |=> armed_r;
  endproperty
  a_arm: assert property (p_arm) else $error("arm command did not set armed flag");

  property p_estrobe_tc;
    m_estrobe && hit && !cmd.arm && !cmd.load |=> !armed_r && !run_r && count_r == $past(load_r);
  endproperty
  a_estrobe_tc: assert property (p_estrobe_tc) else $error("edge strobe TC did not reload and disarm");

  property p_retrig_stop;
    m_retrig && hit && !cmd.disarm |=> !run_r && armed_r;
  endproperty
  a_retrig_stop: assert property (p_retrig_stop) else $error("one-shot TC did not stop while armed");

  property p_retrig_free;
    m_retrig && armed_r && run_r && src_pulse && !tc_r && !pend_r && !at_tc && !cmd.load |=> !$stable(count_r);
  endproperty
  a_retrig_free: assert property (p_retrig_free) else $error("triggered one-shot missed a source edge");

  property p_pend_load;
    go && pend_r && !cmd.load |=> count_r == $past(load_r);
  endproperty
  a_pend_load: assert property (p_pend_load) else $error("retrigger edge did not load from load register");

  property p_relsel_twice;
    m_relsel && hit && phase_r && !cmd.arm |=> !armed_r && !phase_r;
  endproperty
  a_relsel_twice: assert property (p_relsel_twice) else $error("second TC did not disarm");

  c_dual_second: cover property (m_dual && hit && phase_r);
  c_estrobe_retrig: cover property (m_estrobe && save_ev && run_r);
  c_relsel_disarm: cover property (m_relsel && hit && phase_r ##1 !armed_r);

endmodule

// [test/grc_host_model.sv]
`timescale 1ns/10ps
// ****************************************************************
// Host command model
// ****************************************************************
module grc_host_model (
  input wire logic clock,
  output grc_pkg::grc_cmd_t cmd,
  output logic mode_wr,
  output logic [15:0] mode_wdata,
  output logic load_wr,
  output logic [15:0] load_wdata,
  output logic hold_wr,
  output logic [15:0] hold_wdata
);
  import grc_pkg::*;
  initial begin
    cmd = '0;
    {mode_wr, load_wr, hold_wr} = 3'h0;
    {mode_wdata, load_wdata, hold_wdata} = '0;
  end
  // Kind 0 arm, 1 disarm, 2 load, 3 mode, 4 load reg, 5 hold reg
  task automatic op(input int k, input logic [15:0] d);
    @(posedge clock);
    cmd <= grc_cmd_t'{arm: k == 0, disarm: k == 1, load: k == 2};
    mode_wr <= k == 3;
    load_wr <= k == 4;
    hold_wr <= k == 5;
    mode_wdata <= d;
    load_wdata <= d;
    hold_wdata <= d;
    @(posedge clock);
    cmd <= '0;
    {mode_wr, load_wr, hold_wr} <= 3'h0;
    // Released data lines show the inverse of the last value
    mode_wdata <= ~d;
    load_wdata <= ~d;
    hold_wdata <= ~d;
    #1;
  endtask
endmodule

// [test/grc_counter_test.sv]
`timescale 1ns/10ps
module grc_counter_test;
  import grc_pkg::*;
  logic clock, rst, src_pulse, gate, mode_wr, load_wr, hold_wr, terminal_count;
  grc_cmd_t cmd;
  logic [15:0] mode_wdata, load_wdata, hold_wdata, mode_word_r, load_r, hold_r, count_r;
  grc_stat_t status;
  int err_count, compares;
  grc_counter dut(.clock(clock), .rst(rst), .src_pulse(src_pulse), .gate(gate), .cmd(cmd),
    .mode_wr(mode_wr), .mode_wdata(mode_wdata), .load_wr(load_wr), .load_wdata(load_wdata),
    .hold_wr(hold_wr), .hold_wdata(hold_wdata), .mode_word_r(mode_word_r), .load_r(load_r),
    .hold_r(hold_r), .count_r(count_r), .terminal_count(terminal_count), .status(status));
  grc_host_model host(.clock(clock), .cmd(cmd), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
    .load_wr(load_wr), .load_wdata(load_wdata), .hold_wr(hold_wr), .hold_wdata(hold_wdata));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic ck(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cs(input logic [15:0] c, input logic t);
    ck(count_r, c);
    ck({15'h0, terminal_count}, {15'h0, t});
  endtask
  task automatic ca(input logic a);
    ck({15'h0, status.armed}, {15'h0, a});
  endtask
  task automatic st(input int n);
    repeat (n) begin
      @(posedge clock);
      src_pulse <= 1'b1;
      @(posedge clock);
      src_pulse <= 1'b0;
    end
    #1;
  endtask
  task automatic gt(input logic v);
    @(posedge clock);
    gate <= v;
    @(posedge clock);
    #1;
  endtask
  task automatic setup(input logic [15:0] m, input logic [15:0] l, input logic [15:0] h, input logic g);
    host.op(1, 16'h0);
    gt(g);
    host.op(3, m);
    host.op(4, l);
    host.op(5, h);
    host.op(2, 16'h0);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    ck(mode_word_r, 16'h0800);
    cs(16'h0, 1'b0);
    ca(1'b0);
  endtask
  task automatic t_dual;
    setup(16'hc060, 16'h2, 16'h4, 1'b0);
    gt(1'b1);
    gt(1'b0);
    st(1);
    cs(16'h2, 1'b0);
    host.op(0, 16'h0);
    gt(1'b1);
    ck({15'h0, status.running}, 16'h1);
    st(1);
    cs(16'h1, 1'b0);
    st(1);
    cs(16'h4, 1'b1);
    ck({15'h0, status.second_phase}, 16'h1);
    gt(1'b0);
    gt(1'b1);
    ck(hold_r, 16'h4);
    st(1);
    cs(16'h4, 1'b0);
    st(3);
    cs(16'h1, 1'b0);
    st(1);
    cs(16'h2, 1'b1);
    st(2);
    cs(16'h2, 1'b0);
  endtask
  task automatic t_lvl;
    setup(16'h8080, 16'h3, 16'h0, 1'b0);
    ck(load_r, 16'h3);
    gt(1'b1);
    ck(hold_r, 16'h0);
    st(1);
    cs(16'h3, 1'b0);
    host.op(0, 16'h0);
    st(1);
    cs(16'h2, 1'b0);
    gt(1'b0);
    st(1);
    cs(16'h2, 1'b0);
    gt(1'b1);
    ck(hold_r, 16'h2);
    ck({15'h0, status.reload_pending}, 16'h1);
    st(1);
    cs(16'h3, 1'b0);
    st(3);
    cs(16'h3, 1'b1);
    ca(1'b0);
    st(1);
    cs(16'h3, 1'b0);
  endtask
  task automatic t_edge;
    setup(16'hc080, 16'h3, 16'h0, 1'b0);
    gt(1'b1);
    ck(hold_r, 16'h0);
    gt(1'b0);
    host.op(0, 16'h0);
    gt(1'b1);
    ck(hold_r, 16'h3);
    gt(1'b0);
    st(1);
    cs(16'h3, 1'b0);
    st(1);
    cs(16'h2, 1'b0);
    gt(1'b1);
    ck(hold_r, 16'h2);
    st(1);
    cs(16'h3, 1'b0);
    st(3);
    cs(16'h3, 1'b1);
    ca(1'b0);
    st(1);
    cs(16'h3, 1'b0);
  endtask
  task automatic t_sync;
    setup(16'h80a0, 16'h2, 16'h0, 1'b0);
    host.op(0, 16'h0);
    gt(1'b1);
    ck(hold_r, 16'h2);
    st(1);
    cs(16'h2, 1'b0);
    st(2);
    cs(16'h2, 1'b1);
    st(3);
    cs(16'h2, 1'b1);
    ca(1'b1);
    gt(1'b0);
    st(2);
    cs(16'h2, 1'b0);
    host.op(1, 16'h0);
    ca(1'b0);
  endtask
  task automatic t_retrig;
    setup(16'hc0a0, 16'h2, 16'h0, 1'b0);
    host.op(0, 16'h0);
    gt(1'b1);
    ck(hold_r, 16'h2);
    gt(1'b0);
    st(1);
    cs(16'h2, 1'b0);
    st(2);
    cs(16'h2, 1'b1);
    st(2);
    cs(16'h2, 1'b0);
    gt(1'b1);
    st(2);
    cs(16'h1, 1'b0);
    ca(1'b1);
  endtask
  task automatic t_relsel;
    setup(16'h00c0, 16'h2, 16'h5, 1'b1);
    cs(16'h5, 1'b0);
    gt(1'b0);
    host.op(0, 16'h0);
    st(4);
    cs(16'h1, 1'b0);
    st(1);
    cs(16'h2, 1'b1);
    gt(1'b1);
    st(3);
    cs(16'h5, 1'b1);
    ca(1'b0);
    st(2);
    cs(16'h5, 1'b0);
  endtask
  task automatic t_up;
    logic [15:0] m[2] = '{16'h0008, 16'h0018};
    logic [15:0] l[2] = '{16'hfffe, 16'h9998};
    for (int i = 0; i < 2; i++) begin
      setup(m[i], l[i], 16'h0, 1'b0);
      host.op(0, 16'h0);
      st(1);
      cs(l[i] + 16'h1, 1'b0);
      st(1);
      cs(l[i], 1'b1);
      st(1);
      cs(l[i], 1'b0);
    end
  endtask
  task automatic t_low;
    setup(16'ha0a0, 16'h2, 16'h0, 1'b1);
    host.op(0, 16'h0);
    st(1);
    cs(16'h2, 1'b0);
    gt(1'b0);
    ck(hold_r, 16'h2);
    ck({15'h0, status.reload_pending}, 16'h1);
    st(2);
    cs(16'h1, 1'b0);
  endtask
  task automatic summarize;
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #(40 * 6000);
    err_count++;
    summarize();
  end
  initial begin
    {rst, src_pulse, gate} = 3'h4;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    #1;
    t_reset();
    t_dual();
    t_lvl();
    t_edge();
    t_sync();
    t_retrig();
    t_relsel();
    t_up();
    t_low();
    summarize();
  end
endmodule
